/* File: rtl/tccu_pkg.sv */
package tccu_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] TCCU_OFF_CTL1   = 8'h00;
  localparam logic [7:0] TCCU_OFF_CTL2   = 8'h04;
  localparam logic [7:0] TCCU_OFF_FLAGS  = 8'h08;
  localparam logic [7:0] TCCU_OFF_CAP1_H = 8'h0c;
  localparam logic [7:0] TCCU_OFF_CAP1_L = 8'h10;
  localparam logic [7:0] TCCU_OFF_CAP2_H = 8'h14;
  localparam logic [7:0] TCCU_OFF_CAP2_L = 8'h18;
  localparam logic [7:0] TCCU_OFF_CMP1_H = 8'h1c;
  localparam logic [7:0] TCCU_OFF_CMP1_L = 8'h20;
  localparam logic [7:0] TCCU_OFF_CMP2_H = 8'h24;
  localparam logic [7:0] TCCU_OFF_CMP2_L = 8'h28;
  localparam logic [7:0] TCCU_OFF_CNT_H  = 8'h2c;
  localparam logic [7:0] TCCU_OFF_CNT_L  = 8'h30;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TCCU_C1_CAP_IE  = 7;
  localparam int TCCU_C1_CMP_IE  = 6;
  localparam int TCCU_C1_FORCE2  = 4;
  localparam int TCCU_C1_FORCE1  = 3;
  localparam int TCCU_C1_LEVEL2  = 2;
  localparam int TCCU_C1_EDGE1   = 1;
  localparam int TCCU_C1_LEVEL1  = 0;
  localparam int TCCU_C2_PINEN1  = 7;
  localparam int TCCU_C2_PINEN2  = 6;
  localparam int TCCU_C2_SPULSE  = 5;
  localparam int TCCU_C2_PWM     = 4;
  localparam int TCCU_C2_CLK_HI  = 3;
  localparam int TCCU_C2_CLK_LO  = 2;
  localparam int TCCU_C2_EDGE2   = 1;
  localparam int TCCU_C2_EXTEDGE = 0;
  localparam int TCCU_F_CAP1     = 7;
  localparam int TCCU_F_CMP1     = 6;
  localparam int TCCU_F_CAP2     = 4;
  localparam int TCCU_F_CMP2     = 3;
  localparam logic [7:0] TCCU_C1_MASK = 8'hdf;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [15:0] TCCU_CNT_RST = 16'hfffc;
  localparam logic [15:0] TCCU_CMP_RST = 16'h8000;
  localparam logic [2:0]  TCCU_PRE_D2  = 3'h1;
  localparam logic [2:0]  TCCU_PRE_D4  = 3'h3;
  localparam logic [2:0]  TCCU_PRE_D8  = 3'h7;

  typedef enum logic [1:0] {
    TCCU_CLK_DIV4 = 2'b00,
    TCCU_CLK_DIV2 = 2'b01,
    TCCU_CLK_DIV8 = 2'b10,
    TCCU_CLK_EXT  = 2'b11
  } tccu_clk_type;

endpackage

/* File: rtl/tccu_edge.sv */
`timescale 1ns/1ps
module tccu_edge
  import tccu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  input  wire logic rising_sel,
  output logic      edge_pulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } tccu_edge_type;

  tccu_edge_type st_r;
  tccu_edge_type st_nxt;

  // ------------------------------------------------------------
  // Synchroniser and edge detector
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.pulse = rising_sel ? (st_r.s2 & ~st_r.s3) : (~st_r.s2 & st_r.s3);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = st_r.pulse;

  AST_EDGE_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    edge_pulse |=> !edge_pulse)
    else $error("edge pulse longer than one cycle");

endmodule

/* File: rtl/tccu_top.sv */
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Selected capture pin edge sets capture flag and loads counter into capture value.
// - Capture interrupt asserts when enable set and global mask clear; else pending.
// - Capture flag clears after status read with flag set, then low byte access.
// - Reading capture high byte blocks captures and flag until low byte read.
// - Capture value always holds counter of the newest capture, overwriting older.
// - Both capture and both compare channels run concurrently and independently.
// - In single pulse or PWM mode only capture channel two captures.
// - Capture pins are always connected; any qualifying edge triggers a capture.
// - Per-channel edge select bits in both control registers; one capture enable.
// - Each compare channel checks its 16-bit value against the counter each tick.
// - Compare values are software owned, untouched by hardware, reset to 8000h.
// - Outside PWM mode a compare match sets the compare flag regardless of pin enable; compare one also needs single pulse off.
// - On match with pin enabled, pin takes the output level; low during reset.
// - A compare match that sets the compare flag requests interrupt if compare enable set and mask clear.
// - Compare flag clears after status read with flag set, then low byte access.
// - Writing compare high byte stops matching until the low byte is written.
// - Pin enable clear keeps pin free, match still flags and may interrupt.
// - At divide by 2 match at value; other clocks match at value plus one.
// - Force bit copies level to enabled pin, no flag and no interrupt.
// - Force bits do nothing in single pulse or PWM mode.
// - Free-running counter starts at FFFCh after reset.
module tccu_top
  import tccu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  capture_pin,
  input  wire logic        ext_clock_pin,
  input  wire logic        irq_global_mask,
  output logic      [1:0]  compare_pin,
  output logic      [1:0]  compare_pin_oe_n,
  output logic             timer_irq
);

  typedef struct packed {
    logic [15:0]      cnt;
    logic [2:0]       pre;
    logic [7:0]       ctl1;
    logic [7:0]       ctl2;
    logic [1:0]       icf;
    logic [1:0]       ocf;
    logic [1:0]       icf_arm;
    logic [1:0]       ocf_arm;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [1:0]       cap_blk;
    logic [1:0]       cmp_inh;
    logic [1:0]       eq_prev;
    logic [1:0]       pin;
    logic [1:0]       pin_oe_n;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } tccu_state_type;

  tccu_state_type st_r;
  tccu_state_type st_nxt;
  logic [1:0]     cap_edge;
  logic           ext_edge;

  function automatic logic hit_addr(input logic [31:0] a, input logic [7:0] off);
    hit_addr = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  function automatic logic [7:0] byte_sel(input logic [15:0] v, input logic hi);
    byte_sel = hi ? v[15:8] : v[7:0];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      tccu_edge u_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (capture_pin[gi]),
        .rising_sel (gi == 0 ? st_r.ctl1[TCCU_C1_EDGE1] : st_r.ctl2[TCCU_C2_EDGE2]),
        .edge_pulse (cap_edge[gi])
      );
    end
  endgenerate

  tccu_edge u_ext (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (ext_clock_pin),
    .rising_sel (st_r.ctl2[TCCU_C2_EXTEDGE]),
    .edge_pulse (ext_edge)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic         tick;
  logic         mode_busy;
  logic         commit;
  logic         wr;
  logic         rd;
  tccu_clk_type csel;
  logic [15:0]  target;
  logic         eq;
  logic         hit;
  logic         cap_ok;
  logic [7:0]   rdat;
  logic         known;
  logic [7:0]   fbits;

  always_comb begin
    st_nxt    = st_r;
    tick      = 1'b0;
    target    = '0;
    eq        = 1'b0;
    hit       = 1'b0;
    cap_ok    = 1'b0;
    rdat      = '0;
    known     = 1'b1;
    fbits     = '0;
    csel      = tccu_clk_type'({st_r.ctl2[TCCU_C2_CLK_HI], st_r.ctl2[TCCU_C2_CLK_LO]});
    mode_busy = st_r.ctl2[TCCU_C2_SPULSE] | st_r.ctl2[TCCU_C2_PWM];
    commit    = psel & penable & st_r.pready;
    wr        = commit & pwrite;
    rd        = commit & ~pwrite;

    // Prescaler and free-running counter
    case (csel)
      TCCU_CLK_DIV2: begin
        tick = (st_r.pre >= TCCU_PRE_D2);
      end
      TCCU_CLK_DIV4: begin
        tick = (st_r.pre >= TCCU_PRE_D4);
      end
      TCCU_CLK_DIV8: begin
        tick = (st_r.pre >= TCCU_PRE_D8);
      end
      default: begin
        tick = ext_edge;
      end
    endcase
    st_nxt.pre = tick ? 3'h0 : st_r.pre + 3'h1;
    if (csel == TCCU_CLK_EXT) begin
      st_nxt.pre = 3'h0;
    end
    if (tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end

    // Status read arms clearing, low byte access clears
    if (rd && hit_addr(paddr, TCCU_OFF_FLAGS)) begin
      st_nxt.icf_arm = {st_r.prdata[TCCU_F_CAP2], st_r.prdata[TCCU_F_CAP1]};
      st_nxt.ocf_arm = {st_r.prdata[TCCU_F_CMP2], st_r.prdata[TCCU_F_CMP1]};
    end
    for (int i = 0; i < 2; i++) begin
      if (commit && hit_addr(paddr, i == 0 ? TCCU_OFF_CAP1_L : TCCU_OFF_CAP2_L)) begin
        if (st_r.icf_arm[i]) begin
          st_nxt.icf[i] = 1'b0;
        end
        st_nxt.icf_arm[i] = 1'b0;
        if (rd) begin
          st_nxt.cap_blk[i] = 1'b0;
        end
      end
      if (rd && hit_addr(paddr, i == 0 ? TCCU_OFF_CAP1_H : TCCU_OFF_CAP2_H)) begin
        st_nxt.cap_blk[i] = 1'b1;
      end
      if (commit && hit_addr(paddr, i == 0 ? TCCU_OFF_CMP1_L : TCCU_OFF_CMP2_L)) begin
        if (st_r.ocf_arm[i]) begin
          st_nxt.ocf[i] = 1'b0;
        end
        st_nxt.ocf_arm[i] = 1'b0;
        if (wr) begin
          st_nxt.cmp[i][7:0] = pwdata[7:0];
          st_nxt.cmp_inh[i]  = 1'b0;
        end
      end
      if (wr && hit_addr(paddr, i == 0 ? TCCU_OFF_CMP1_H : TCCU_OFF_CMP2_H)) begin
        st_nxt.cmp[i][15:8] = pwdata[7:0];
        st_nxt.cmp_inh[i]   = 1'b1;
      end

      // Capture channel, set wins over clear
      cap_ok = cap_edge[i] & ~st_r.cap_blk[i] & ~(i == 0 && mode_busy);
      if (cap_ok) begin
        st_nxt.cap[i] = st_r.cnt;
        st_nxt.icf[i] = 1'b1;
      end

      // Compare channel
      target = (csel == TCCU_CLK_DIV2) ? st_r.cmp[i] : st_r.cmp[i] + 16'h0001;
      eq     = (st_r.cnt == target);
      hit    = eq & ~st_r.eq_prev[i] & ~st_r.cmp_inh[i];
      st_nxt.eq_prev[i] = eq;
      if (hit && !st_r.ctl2[TCCU_C2_PWM] && !(i == 0 && st_r.ctl2[TCCU_C2_SPULSE])) begin
        st_nxt.ocf[i] = 1'b1;
      end
      if (hit && st_r.pin_oe_n[i] == 1'b0) begin
        st_nxt.pin[i] = st_r.ctl1[i == 0 ? TCCU_C1_LEVEL1 : TCCU_C1_LEVEL2];
      end
    end

    // Control registers and forced output
    if (wr && hit_addr(paddr, TCCU_OFF_CTL1)) begin
      st_nxt.ctl1 = pwdata[7:0] & TCCU_C1_MASK;
      st_nxt.ctl1[TCCU_C1_FORCE1] = 1'b0;
      st_nxt.ctl1[TCCU_C1_FORCE2] = 1'b0;
      if (!mode_busy) begin
        if (pwdata[TCCU_C1_FORCE1] && st_r.ctl2[TCCU_C2_PINEN1]) begin
          st_nxt.pin[0] = pwdata[TCCU_C1_LEVEL1];
        end
        if (pwdata[TCCU_C1_FORCE2] && st_r.ctl2[TCCU_C2_PINEN2]) begin
          st_nxt.pin[1] = pwdata[TCCU_C1_LEVEL2];
        end
      end
    end
    if (wr && hit_addr(paddr, TCCU_OFF_CTL2)) begin
      st_nxt.ctl2 = pwdata[7:0];
    end
    st_nxt.pin_oe_n = ~{st_r.ctl2[TCCU_C2_PINEN2], st_r.ctl2[TCCU_C2_PINEN1]};

    // Interrupt request held while any enabled flag is pending and the global mask is clear
    st_nxt.irq = ~irq_global_mask &
                 ((st_r.ctl1[TCCU_C1_CAP_IE] & |st_r.icf) |
                  (st_r.ctl1[TCCU_C1_CMP_IE] & |st_r.ocf));

    // Read data mux
    fbits[TCCU_F_CAP1] = st_r.icf[0];
    fbits[TCCU_F_CAP2] = st_r.icf[1];
    fbits[TCCU_F_CMP1] = st_r.ocf[0];
    fbits[TCCU_F_CMP2] = st_r.ocf[1];
    if (paddr[31:8] != 24'h000000) begin
      known = 1'b0;
    end else begin
      case (paddr[7:0])
        TCCU_OFF_CTL1:   rdat = st_r.ctl1;
        TCCU_OFF_CTL2:   rdat = st_r.ctl2;
        TCCU_OFF_FLAGS:  rdat = fbits;
        TCCU_OFF_CAP1_H: rdat = byte_sel(st_r.cap[0], 1'b1);
        TCCU_OFF_CAP1_L: rdat = byte_sel(st_r.cap[0], 1'b0);
        TCCU_OFF_CAP2_H: rdat = byte_sel(st_r.cap[1], 1'b1);
        TCCU_OFF_CAP2_L: rdat = byte_sel(st_r.cap[1], 1'b0);
        TCCU_OFF_CMP1_H: rdat = byte_sel(st_r.cmp[0], 1'b1);
        TCCU_OFF_CMP1_L: rdat = byte_sel(st_r.cmp[0], 1'b0);
        TCCU_OFF_CMP2_H: rdat = byte_sel(st_r.cmp[1], 1'b1);
        TCCU_OFF_CMP2_L: rdat = byte_sel(st_r.cmp[1], 1'b0);
        TCCU_OFF_CNT_H:  rdat = byte_sel(st_r.cnt, 1'b1);
        TCCU_OFF_CNT_L:  rdat = byte_sel(st_r.cnt, 1'b0);
        default:         known = 1'b0;
      endcase
    end

    // APB handshake, one wait state
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.prdata  = {24'h000000, rdat};
      st_nxt.pslverr = ~known;
    end else begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.cnt      <= TCCU_CNT_RST;
      st_r.cmp[0]   <= TCCU_CMP_RST;
      st_r.cmp[1]   <= TCCU_CMP_RST;
      st_r.pin_oe_n <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign compare_pin      = st_r.pin;
  assign compare_pin_oe_n = st_r.pin_oe_n;
  assign timer_irq        = st_r.irq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CAP_LOAD: assert property (cap_edge[1] && !st_r.cap_blk[1]
    |=> st_r.icf[1] && st_r.cap[1] == $past(st_r.cnt))
    else $error("capture two did not load counter");

  AST_CAP_BLOCK: assert property (st_r.cap_blk[0] && !st_r.icf[0]
    |=> !st_r.icf[0] || $past(commit))
    else $error("capture flag set while blocked");

  AST_CAP1_MODE: assert property (mode_busy && !st_r.icf[0] && !commit
    |=> !st_r.icf[0])
    else $error("capture one active in pulse mode");

  AST_IRQ: assert property (st_r.ctl1[TCCU_C1_CAP_IE] && st_r.icf[0] && !irq_global_mask
    |=> timer_irq)
    else $error("capture interrupt missing");

  AST_IRQ_MASK: assert property ($past(irq_global_mask) |-> !timer_irq)
    else $error("interrupt while masked");

  AST_CMP_INH: assert property (st_r.cmp_inh[0] && st_r.cmp_inh[0] == $past(st_r.cmp_inh[0])
    && $past(st_r.ocf[0]) == 1'b0 |-> !st_r.ocf[0])
    else $error("compare matched while inhibited");

  AST_CMP_RST: assert property ($rose(presetn) |-> st_r.cmp[0] == TCCU_CMP_RST)
    else $error("compare reset value wrong");

  AST_PIN_FORCE: assert property (wr && hit_addr(paddr, TCCU_OFF_CTL1) && !mode_busy
    && pwdata[TCCU_C1_FORCE1] && st_r.ctl2[TCCU_C2_PINEN1]
    |=> compare_pin[0] == $past(pwdata[TCCU_C1_LEVEL1]))
    else $error("forced output not applied");

  AST_FLAG_CLEAR: assert property (commit && hit_addr(paddr, TCCU_OFF_CMP2_L)
    && st_r.ocf_arm[1]
    && ((!(st_r.cnt == st_r.cmp[1]) && !(st_r.cnt == st_r.cmp[1] + 16'h0001))
        || (st_r.eq_prev[1] && $stable(st_r.cnt) && $stable(st_r.cmp[1]) && $stable(st_r.ctl2)))
    |=> !st_r.ocf[1])
    else $error("compare flag not cleared");

  AST_PREADY: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  COV_CAPTURE: cover property (cap_edge[0] ##1 st_r.icf[0]);
  COV_MATCH: cover property (st_r.ocf[1] && !compare_pin_oe_n[1]);
  COV_CLEAR: cover property (st_r.icf_arm[0] ##[1:20] !st_r.icf[0]);
  COV_IRQ: cover property (timer_irq);

endmodule

/* File: test/tccu_partner.sv */
`timescale 1ns/1ps
module tccu_partner (
  input  wire logic       pclk,
  output logic      [1:0] capture_pin,
  output logic            ext_clock_pin,
  input  wire logic [1:0] compare_pin,
  input  wire logic [1:0] compare_pin_oe_n
);
  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  initial begin
    capture_pin   = 2'b00;
    ext_clock_pin = 1'b0;
  end

  // Drive a capture pin level and hold it past the synchroniser
  task automatic drive_capture(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 0) begin
      capture_pin[0] <= lvl;
    end else begin
      capture_pin[1] <= lvl;
    end
    repeat (8) @(posedge pclk);
  endtask

  // One rising edge of the external clock, far below a quarter of pclk
  task automatic tick();
    @(posedge pclk);
    ext_clock_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_clock_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

/* File: test/tccu_tb.sv */
`timescale 1ns/1ps
module tb;
  import tccu_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  capture_pin;
  logic        ext_clock_pin;
  logic        irq_global_mask;
  logic [1:0]  compare_pin;
  logic [1:0]  compare_pin_oe_n;
  logic        timer_irq;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [15:0] cnt;
  logic [31:0] rdata;
  logic        rerr;

  tccu_top DUT (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .capture_pin      (capture_pin),
    .ext_clock_pin    (ext_clock_pin),
    .irq_global_mask  (irq_global_mask),
    .compare_pin      (compare_pin),
    .compare_pin_oe_n (compare_pin_oe_n),
    .timer_irq        (timer_irq)
  );

  tccu_partner P (
    .pclk             (pclk),
    .capture_pin      (capture_pin),
    .ext_clock_pin    (ext_clock_pin),
    .compare_pin      (compare_pin),
    .compare_pin_oe_n (compare_pin_oe_n)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ------------------------------------------------------------
  // Verdict and timeout
  // ------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Compares and bus access
  // ------------------------------------------------------------
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk_byte(name, exp, rdata[7:0]);
  endtask

  // High byte, status read, low byte
  task automatic set_cmp(input logic [7:0] hi_a, input logic [7:0] lo_a, input logic [15:0] v);
    wr(hi_a, v[15:8]);
    apb(1'b0, TCCU_OFF_FLAGS, 8'h00);
    wr(lo_a, v[7:0]);
  endtask

  task automatic pulse(input int ch);
    P.drive_capture(ch, 1'b1);
    P.drive_capture(ch, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 32'h0;
    pwdata          = 32'h0;
    irq_global_mask = 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk_byte("pins_in_reset", 8'h0c, {4'h0, compare_pin_oe_n, compare_pin});
    chk_bit("irq_in_reset", 1'b0, timer_irq);
    @(posedge pclk);
    presetn <= 1'b1;
    rd("cnt_hi", TCCU_OFF_CNT_H, 8'hff);
    rd("cmp1_hi", TCCU_OFF_CMP1_H, 8'h80);
    rd("cmp1_lo", TCCU_OFF_CMP1_L, 8'h00);
    rd("cmp2_hi", TCCU_OFF_CMP2_H, 8'h80);
    rd("unmapped", 8'h34, 8'h00);
    chk_bit("unmapped_err", 1'b1, rerr);
    // Counter frozen on external clock, capture one on rising edge
    wr(TCCU_OFF_CTL2, 8'h0d);
    wr(TCCU_OFF_CTL1, 8'h82);
    apb(1'b0, TCCU_OFF_CNT_H, 8'h00);
    cnt[15:8] = rdata[7:0];
    apb(1'b0, TCCU_OFF_CNT_L, 8'h00);
    cnt[7:0] = rdata[7:0];
    P.tick();
    cnt++;
    pulse(0);
    rd("cap1_lo_unarmed", TCCU_OFF_CAP1_L, cnt[7:0]);
    rd("flags_cap1", TCCU_OFF_FLAGS, 8'h80);
    chk_bit("irq_masked", 1'b0, timer_irq);
    @(posedge pclk) irq_global_mask <= 1'b0;
    repeat (3) @(negedge pclk);
    chk_bit("irq_pending", 1'b1, timer_irq);
    rd("cap1_hi", TCCU_OFF_CAP1_H, cnt[15:8]);
    rd("cap1_lo", TCCU_OFF_CAP1_L, cnt[7:0]);
    rd("flags_cleared", TCCU_OFF_FLAGS, 8'h00);
    // Locked by high byte read
    rd("cap1_hi_lock", TCCU_OFF_CAP1_H, cnt[15:8]);
    P.tick();
    pulse(0);
    rd("flags_blocked", TCCU_OFF_FLAGS, 8'h00);
    rd("cap1_lo_kept", TCCU_OFF_CAP1_L, cnt[7:0]);
    cnt++;
    pulse(0);
    rd("flags_recap", TCCU_OFF_FLAGS, 8'h80);
    rd("cap1_hi_new", TCCU_OFF_CAP1_H, cnt[15:8]);
    rd("cap1_lo_new", TCCU_OFF_CAP1_L, cnt[7:0]);
    // Compare one with pin enabled
    wr(TCCU_OFF_CTL2, 8'h8d);
    wr(TCCU_OFF_CTL1, 8'hc3);
    set_cmp(TCCU_OFF_CMP1_H, TCCU_OFF_CMP1_L, cnt);
    rd("flags_at_value", TCCU_OFF_FLAGS, 8'h00);
    @(negedge pclk);
    chk_byte("pins_enabled", 8'h08, {4'h0, compare_pin_oe_n, compare_pin});
    P.tick();
    cnt++;
    @(negedge pclk);
    chk_bit("cmp1_pin", 1'b1, compare_pin[0]);
    chk_bit("cmp_irq", 1'b1, timer_irq);
    rd("flags_cmp1", TCCU_OFF_FLAGS, 8'h40);
    rd("cmp1_lo_rb", TCCU_OFF_CMP1_L, cnt[7:0] - 8'h01);
    rd("flags_cmp1_clr", TCCU_OFF_FLAGS, 8'h00);
    // Compare two inhibited, then with pin disabled
    set_cmp(TCCU_OFF_CMP2_H, TCCU_OFF_CMP2_L, cnt);
    wr(TCCU_OFF_CMP2_H, cnt[15:8]);
    P.tick();
    cnt++;
    rd("flags_inhibit", TCCU_OFF_FLAGS, 8'h00);
    set_cmp(TCCU_OFF_CMP2_H, TCCU_OFF_CMP2_L, cnt);
    P.tick();
    cnt++;
    rd("flags_cmp2", TCCU_OFF_FLAGS, 8'h08);
    @(negedge pclk);
    chk_byte("pin2_free", 8'h09, {4'h0, compare_pin_oe_n, compare_pin});
    chk_bit("cmp2_irq", 1'b1, timer_irq);
    rd("cmp2_lo_rb", TCCU_OFF_CMP2_L, cnt[7:0] - 8'h01);
    rd("flags_cmp2_clr", TCCU_OFF_FLAGS, 8'h00);
    // Forced output, then ignored in pwm mode
    wr(TCCU_OFF_CTL1, 8'hc8);
    @(negedge pclk);
    chk_bit("force_low", 1'b0, compare_pin[0]);
    rd("flags_force", TCCU_OFF_FLAGS, 8'h00);
    chk_bit("force_irq", 1'b0, timer_irq);
    wr(TCCU_OFF_CTL2, 8'h9d);
    wr(TCCU_OFF_CTL1, 8'hc9);
    @(negedge pclk);
    chk_bit("force_pwm", 1'b0, compare_pin[0]);
    // Channel one idle in pwm mode, channel two on falling edge
    pulse(0);
    P.drive_capture(1, 1'b1);
    rd("flags_rise2", TCCU_OFF_FLAGS, 8'h00);
    P.drive_capture(1, 1'b0);
    rd("flags_fall2", TCCU_OFF_FLAGS, 8'h10);
    // Divide by two matches at the value itself, then single pulse mode
    set_cmp(TCCU_OFF_CMP1_H, TCCU_OFF_CMP1_L, cnt + 16'h0010);
    wr(TCCU_OFF_CTL2, 8'h84);
    repeat (100) if (compare_pin[0] !== 1'b1) @(negedge pclk);
    chk_bit("cmp1_pin_div2", 1'b1, compare_pin[0]);
    rd("cnt_lo_div2", TCCU_OFF_CNT_L, cnt[7:0] + 8'h11);
    wr(TCCU_OFF_CTL2, 8'ha4);
    wr(TCCU_OFF_CTL1, 8'hc8);
    @(negedge pclk);
    chk_bit("force_spulse", 1'b1, compare_pin[0]);
    pulse(0);
    rd("flags_spulse", TCCU_OFF_FLAGS, 8'h50);
    stop_test();
  end
endmodule
